// [src/caa_pkg.sv]
// Purpose: Shared constants for the converter alarm aggregator
// Assumes: Byte-wide register port, 12-bit register addresses
// Notes:   Offsets are the printed register addresses
package caa_pkg;

  // Register addresses
  localparam logic [11:0] ADDR_ALARM_SUMMARY = 12'h2C0;
  localparam logic [11:0] ADDR_ALARM_STATUS  = 12'h2C1;
  localparam logic [11:0] ADDR_ALARM_MASK    = 12'h2C2;
  localparam logic [11:0] ADDR_LANE_ERR_LO   = 12'h2C4;
  localparam logic [11:0] ADDR_LANE_ERR_HI   = 12'h2C5;

  // Status, mask and summary field positions
  localparam int BIT_CLK  = 0;
  localparam int BIT_NCO  = 1;
  localparam int BIT_REAL = 2;
  localparam int BIT_LINK = 3;
  localparam int BIT_PLL  = 4;
  localparam int BIT_FIFO = 5;
  localparam int BIT_SUMMARY = 0;

  // Reset values
  localparam logic [5:0]  RST_STATUS   = 6'h3F;
  localparam logic [5:0]  RST_MASK     = 6'h3F;
  localparam logic [15:0] RST_LANE_ERR = 16'hFFFF;
  localparam logic        RST_SUMMARY  = 1'h0;

  // Calibration-status pin selector code that routes the alarm
  localparam logic [1:0] CALSEL_ALARM = 2'h1;

endpackage : caa_pkg

// [src/caa_sticky.sv]
// Purpose: Generic bank of sticky flags with write-one-to-clear
// Assumes: Set and clear are single-cycle qualified by the caller
// Notes:   Set beats clear so no event is lost
module caa_sticky #(
  parameter int                W       = 6,
  parameter logic [W-1:0]      RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         soft_rst_i,
  // Flag control
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);

  typedef struct packed {
    logic [W-1:0] flags;
  } caa_sticky_s;

  caa_sticky_s state_reg;
  caa_sticky_s state_next;

  // Set wins over a same-cycle clear
  always_comb begin
    state_next = state_reg;
    if (soft_rst_i) begin
      state_next.flags = RST_VAL;
    end else begin
      state_next.flags = (state_reg.flags & ~clr_i) | set_i;
    end
  end

  // State register, frozen while enable low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg.flags <= RST_VAL;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign flags_o = state_reg.flags;

endmodule : caa_sticky

// [src/caa_alarm_top.sv]
// Purpose: Alarm collection, masking and summary for the converter link
// Assumes: Simple byte-wide register port synchronous to clk_i
// Notes:   Event inputs are level or pulse conditions sampled each cycle
// Function
// - Summary bit is one when any unmasked status flag is set.
// - Summary register is read-only; writes do nothing.
// - Summary drives calibration status pin when selector picks it.
// - Lane FIFO flag sets on any active lane overflow or underflow.
// - Writing one clears a flag; writing zero leaves it.
// - PLL flag sets whenever the PLL is out of lock.
// - 8b/10b: link flag sets when enabled but not transmitting data.
// - 64b/66b: link flag sets at startup and on realignment.
// - Realignment flag sets when SYSREF realigns internal clocks.
// - NCO flag sets on link off, NCO sync, or phase mismatch.
// - Clock flag sets when channel dividers disagree.
// - Power-on or soft reset sets all six flags to 0x3F.
// - With link disabled, only the clock flag must be meaningful.
// - Mask bits block flags from the summary; reset to 0x3F.
// - Per-lane error bits set per lane, write-one clears.
// - Clearing the lane FIFO flag clears every per-lane bit.
module caa_alarm_top (
  // Clock, enable, reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        soft_rst_i,
  // Register port
  input  wire logic [11:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Link and clocking condition inputs
  input  wire logic        link_enable_i,
  input  wire logic        link_mode_66b_i,
  input  wire logic        link_in_data_state_i,
  input  wire logic        link_realign_i,
  input  wire logic        pll_locked_i,
  input  wire logic [15:0] lane_active_i,
  input  wire logic [15:0] lane_fifo_err_i,
  input  wire logic        sysref_realign_i,
  input  wire logic        nco_sync_i,
  input  wire logic        nco_phase_mismatch_i,
  input  wire logic        divider_mismatch_i,
  input  wire logic [1:0]  cal_status_sel_i,
  // Pin outputs
  output logic             cal_status_pin_o,
  output logic             alarm_summary_o
);

  // Timing and hazards in short
  // Causes are levels, sampled on every enabled edge.
  // Set beats a same-cycle clear; a held cause re-sets next edge.
  // Summary and pin trail flags, clears and mask writes by one cycle.
  // Link-off flags are stale; software clears all after enabling.
  // Divider flag stays meaningful with the link off.
  // 64b/66b startup: enable seen high after low, or high out of reset.
  // Masked flag hidden from summary, still readable in status.
  // Read data stands one cycle; idle cycles read zero.
  // Unmapped addresses read zero and ignore writes.
  // All state freezes while the clock enable is low.

  typedef struct packed {
    logic [5:0] mask;
    logic       link_en_d;
    logic       summary;
    logic       pin;
    logic [7:0] rdata;
  } caa_top_s;

  caa_top_s state_reg;
  caa_top_s state_next;

  logic [5:0]  status_flags;
  logic [15:0] lane_flags;
  logic [5:0]  status_set;
  logic [5:0]  status_clr;
  logic [15:0] lane_set;
  logic [15:0] lane_clr;
  logic        link_cause;
  logic        wr_status;
  logic        wr_lane_lo;
  logic        wr_lane_hi;
  logic        wr_mask;
  logic        link_start;
  logic        nco_cause;

  // Write strobe aimed at one address; shared by every write target
  function automatic logic wr_hit(
    input logic        wr,
    input logic [11:0] addr,
    input logic [11:0] target
  );
    return wr && (addr == target);
  endfunction : wr_hit

  // Address decode for write-one-to-clear targets
  assign wr_status  = wr_hit(reg_wr_i, reg_addr_i, caa_pkg::ADDR_ALARM_STATUS);
  assign wr_lane_lo = wr_hit(reg_wr_i, reg_addr_i, caa_pkg::ADDR_LANE_ERR_LO);
  assign wr_lane_hi = wr_hit(reg_wr_i, reg_addr_i, caa_pkg::ADDR_LANE_ERR_HI);
  // Mask is a plain read/write register
  assign wr_mask    = wr_hit(reg_wr_i, reg_addr_i, caa_pkg::ADDR_ALARM_MASK);

  // Startup edge; link_en_d resets low so enable high out of reset counts
  assign link_start = link_enable_i && !state_reg.link_en_d;
  // NCO upset: link off, sync event or channel phase mismatch
  assign nco_cause  = !link_enable_i || nco_sync_i || nco_phase_mismatch_i;

  // Flag causes; causes are levels so a held cause re-sets after a clear
  always_comb begin
    lane_set = lane_fifo_err_i & lane_active_i;
    if (link_mode_66b_i) begin
      link_cause = link_start || link_realign_i;
    end else begin
      link_cause = link_enable_i && !link_in_data_state_i;
    end
    status_set = '0;
    status_set[caa_pkg::BIT_FIFO] = |lane_set;
    status_set[caa_pkg::BIT_PLL]  = !pll_locked_i;
    status_set[caa_pkg::BIT_LINK] = link_cause;
    status_set[caa_pkg::BIT_REAL] = sysref_realign_i;
    // NCO upset causes; link-off state left as a cause
    status_set[caa_pkg::BIT_NCO]  = nco_cause;
    status_set[caa_pkg::BIT_CLK]  = divider_mismatch_i;
  end

  // Write-one-to-clear decode
  always_comb begin
    status_clr = wr_status ? reg_wdata_i[5:0] : 6'h00;
    // lane flag clear empties lane vector
    if (wr_status && reg_wdata_i[caa_pkg::BIT_FIFO]) begin
      lane_clr = 16'hFFFF;
    end else begin
      lane_clr = {(wr_lane_hi ? reg_wdata_i : 8'h00), (wr_lane_lo ? reg_wdata_i : 8'h00)};
    end
  end

  // One clear word serves all six flags
  // status flags reset to 0x3F
  caa_sticky #(
    .W       (6),
    .RST_VAL (caa_pkg::RST_STATUS)
  ) u_status (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .soft_rst_i (soft_rst_i),
    .set_i      (status_set),
    .clr_i      (status_clr),
    .flags_o    (status_flags)
  );

  // Per-lane error vector, all ones after reset
  // Lanes outside lane_active_i never set their bit except by reset or soft reset
  caa_sticky #(
    .W       (16),
    .RST_VAL (caa_pkg::RST_LANE_ERR)
  ) u_lanes (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .soft_rst_i (soft_rst_i),
    .set_i      (lane_set),
    .clr_i      (lane_clr),
    .flags_o    (lane_flags)
  );

  // Next-state logic: mask, summary, pin and read data
  always_comb begin
    state_next = state_reg;
    state_next.link_en_d = link_enable_i;
    if (soft_rst_i) begin
      state_next.mask = caa_pkg::RST_MASK;
    end else if (wr_mask) begin
      state_next.mask = reg_wdata_i[5:0];
    end
    state_next.summary = |(status_flags & ~state_reg.mask);
    state_next.pin = (cal_status_sel_i == caa_pkg::CALSEL_ALARM) ? state_next.summary : 1'b0;
    // summary has no write path; reads only
    state_next.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        caa_pkg::ADDR_ALARM_SUMMARY: state_next.rdata = {7'h00, state_reg.summary};
        caa_pkg::ADDR_ALARM_STATUS:  state_next.rdata = {2'h0, status_flags};
        caa_pkg::ADDR_ALARM_MASK:    state_next.rdata = {2'h0, state_reg.mask};
        caa_pkg::ADDR_LANE_ERR_LO:   state_next.rdata = lane_flags[7:0];
        caa_pkg::ADDR_LANE_ERR_HI:   state_next.rdata = lane_flags[15:8];
        default:                     state_next.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // State register; summary lags flags by one cycle
  // Every top-level output comes straight from these flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg.mask      <= caa_pkg::RST_MASK;
      state_reg.link_en_d <= 1'b0;
      state_reg.summary   <= caa_pkg::RST_SUMMARY;
      state_reg.pin       <= 1'b0;
      state_reg.rdata     <= 8'h00;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o      = state_reg.rdata;
  assign alarm_summary_o  = state_reg.summary;
  assign cal_status_pin_o = state_reg.pin;

endmodule : caa_alarm_top

// [sim/caa_alarm_monitor.sv]
// Purpose: Port-level assertions for the alarm aggregator
// Assumes: One clock, byte register port
// Notes:   Bound into every caa_alarm_top
module caa_alarm_monitor (
  // Clock
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        soft_rst_i,
  // Bus
  input wire logic [11:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  // Pins
  input wire logic        divider_mismatch_i,
  input wire logic [1:0]  cal_status_sel_i,
  input wire logic        cal_status_pin_o,
  input wire logic        alarm_summary_o
);
  localparam logic [11:0] SU = caa_pkg::ADDR_ALARM_SUMMARY;
  localparam logic [11:0] ST = caa_pkg::ADDR_ALARM_STATUS;
  localparam logic [11:0] MK = caa_pkg::ADDR_ALARM_MASK;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Summary takes two edges to reflect a mask change
  pin_route_a: assert property ($stable(cal_status_sel_i) |-> cal_status_pin_o ==
    (alarm_summary_o && cal_status_sel_i == caa_pkg::CALSEL_ALARM)) else $error("pin route");
  sum_rsvd_a: assert property (reg_rd_i && reg_addr_i == SU |=> reg_rdata_o[7:1] == 7'h00)
    else $error("summary upper bits");
  rst_quiet_a: assert property ($past(rst_i) |-> !alarm_summary_o)
    else $error("summary after reset");
  soft_quiet_a: assert property (soft_rst_i && ce_i ##1 ce_i |=> !alarm_summary_o)
    else $error("summary after soft reset");
  mask_quiet_a: assert property (reg_wr_i && ce_i && reg_addr_i == MK &&
    reg_wdata_i[5:0] == 6'h3F ##1 ce_i |=> !alarm_summary_o) else $error("mask ignored");
  clear_flag_a: assert property (reg_wr_i && ce_i && reg_addr_i == ST && reg_wdata_i[0] &&
    !divider_mismatch_i && !soft_rst_i ##1 reg_rd_i && ce_i && reg_addr_i == ST
    |=> !reg_rdata_o[0]) else $error("flag not cleared");
  sticky_flag_a: assert property (divider_mismatch_i && ce_i ##1
    reg_rd_i && ce_i && reg_addr_i == ST |=> reg_rdata_o[0]) else $error("clock flag not set");
  soft_flags_a: assert property (soft_rst_i && ce_i && !reg_wr_i ##1
    reg_rd_i && ce_i && reg_addr_i == ST |=> reg_rdata_o[5:0] == 6'h3F)
    else $error("soft reset flags");
  cover property (alarm_summary_o);
  cover property (cal_status_pin_o);
  cover property (soft_rst_i);
endmodule : caa_alarm_monitor

bind caa_alarm_top caa_alarm_monitor mon (
  .clk_i              (clk_i),
  .rst_i              (rst_i),
  .ce_i               (ce_i),
  .soft_rst_i         (soft_rst_i),
  .reg_addr_i         (reg_addr_i),
  .reg_wr_i           (reg_wr_i),
  .reg_rd_i           (reg_rd_i),
  .reg_wdata_i        (reg_wdata_i),
  .reg_rdata_o        (reg_rdata_o),
  .divider_mismatch_i (divider_mismatch_i),
  .cal_status_sel_i   (cal_status_sel_i),
  .cal_status_pin_o   (cal_status_pin_o),
  .alarm_summary_o    (alarm_summary_o)
);

// [sim/caa_alarm_top_tb_top.sv]
// Purpose: Self-checking bench for the alarm aggregator
// Assumes: Causes idle unless pulsed, 8b/10b link mode first, then 64b/66b
// Notes:   Register tasks enter and leave on a rising edge
module caa_alarm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] SU = caa_pkg::ADDR_ALARM_SUMMARY;
  localparam logic [11:0] ST = caa_pkg::ADDR_ALARM_STATUS;
  localparam logic [11:0] MK = caa_pkg::ADDR_ALARM_MASK;
  localparam logic [11:0] LL = caa_pkg::ADDR_LANE_ERR_LO;
  localparam logic [11:0] LH = caa_pkg::ADDR_LANE_ERR_HI;
  logic        clk_i = 1'b0, rst_i = 1'b1, soft_rst_i = 1'b0, reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0, link_enable_i = 1'b1, alarm_summary_o, cal_status_pin_o;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
  logic [5:0]  f = 6'h00;
  logic [1:0]  cal_status_sel_i = 2'h0;
  int          n_mismatch = 0, checks = 0, cyc = 0;
  logic        ce_i = 1'b1, link_mode_66b_i = 1'b0, link_realign_i = 1'b0;
  logic        nco_phase_mismatch_i = 1'b0;
  // Tied: only lane 3 active, so lane logic is reached through one lane
  wire  [15:0] lane_active_i = 16'h0008;
  // One fault cause per bit of f, bit order of the status flags
  wire         divider_mismatch_i = f[0], nco_sync_i = f[1], sysref_realign_i = f[2];
  wire         link_in_data_state_i = !f[3], pll_locked_i = !f[4];
  wire  [15:0] lane_fifo_err_i = {12'h000, f[5], 3'h0};
  caa_alarm_top dut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .ce_i                 (ce_i),
    .soft_rst_i           (soft_rst_i),
    .reg_addr_i           (reg_addr_i),
    .reg_wr_i             (reg_wr_i),
    .reg_rd_i             (reg_rd_i),
    .reg_wdata_i          (reg_wdata_i),
    .reg_rdata_o          (reg_rdata_o),
    .link_enable_i        (link_enable_i),
    .link_mode_66b_i      (link_mode_66b_i),
    .link_in_data_state_i (link_in_data_state_i),
    .link_realign_i       (link_realign_i),
    .pll_locked_i         (pll_locked_i),
    .lane_active_i        (lane_active_i),
    .lane_fifo_err_i      (lane_fifo_err_i),
    .sysref_realign_i     (sysref_realign_i),
    .nco_sync_i           (nco_sync_i),
    .nco_phase_mismatch_i (nco_phase_mismatch_i),
    .divider_mismatch_i   (divider_mismatch_i),
    .cal_status_sel_i     (cal_status_sel_i),
    .cal_status_pin_o     (cal_status_pin_o),
    .alarm_summary_o      (alarm_summary_o)
  );
  // Clock and hang guard
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [7:0] e);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge clk_i);
    chk("rdata", e, reg_rdata_o);
    @(posedge clk_i);
  endtask : rd
  task automatic pins(input logic e);
    @(negedge clk_i);
    chk("summary", {7'h00, e}, {7'h00, alarm_summary_o});
    chk("pin", {7'h00, e}, {7'h00, cal_status_pin_o});
    @(posedge clk_i);
  endtask : pins
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ST, 8'h3F);
    rd(MK, 8'h3F);
    rd(SU, 8'h00);
    rd(LH, 8'hFF);
    wr(LH, 8'hFF);
    rd(LH, 8'h00);
    wr(ST, 8'h3F);
    rd(ST, 8'h00);
    rd(LL, 8'h00);
    wr(SU, 8'hFF);
    rd(SU, 8'h00);
    $display("test reset done");
    cal_status_sel_i <= caa_pkg::CALSEL_ALARM;
    for (int i = 0; i < 6; i++) begin
      wr(MK, ~(8'h01 << i) & 8'h3F);
      f <= 6'h01 << i;
      @(posedge clk_i);
      f <= 6'h00;
      rd(ST, 8'h01 << i);
      pins(1'b1);
      if (i == 5) rd(LL, 8'h08);
      wr(ST, 8'h01 << i);
      rd(ST, 8'h00);
      if (i == 5) rd(LL, 8'h00);
      pins(1'b0);
    end
    $display("test flags done");
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    rd(ST, 8'h3F);
    pins(1'b0);
    rd(MK, 8'h3F);
    wr(MK, 8'h3F);
    $display("test soft done");
    // Wide-code link: restart the link, then clear as software should
    link_mode_66b_i <= 1'b1;
    link_enable_i   <= 1'b0;
    @(posedge clk_i);
    link_enable_i   <= 1'b1;
    @(posedge clk_i);
    wr(ST, 8'h3F);
    rd(ST, 8'h00);
    // Second startup: link-off sets NCO flag, enable edge sets link flag
    link_enable_i   <= 1'b0;
    @(posedge clk_i);
    link_enable_i   <= 1'b1;
    @(posedge clk_i);
    rd(ST, 8'h0A);
    wr(ST, 8'h0A);
    rd(ST, 8'h00);
    // Realign event, then a phase mismatch on top of it
    link_realign_i <= 1'b1;
    @(posedge clk_i);
    link_realign_i <= 1'b0;
    rd(ST, 8'h08);
    nco_phase_mismatch_i <= 1'b1;
    @(posedge clk_i);
    nco_phase_mismatch_i <= 1'b0;
    rd(ST, 8'h0A);
    wr(ST, 8'h0A);
    rd(ST, 8'h00);
    $display("test wide link done");
    test_done;
  end
endmodule : caa_alarm_top_tb_top
